/* File: src/pcr_port_regs.v */
/*
 * PHY port control and cable test register bank with interrupt status.
 * Assumes a single clock, a cable test engine and PHY core on the same
 * clock, and a register port whose master never overlaps strobes.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "pcr_regs.vh"

module pcr_port_regs #(
    parameter CNT_W = 9
) (
    input  wire                    clock_i,
    input  wire                    resetn_i,
    input  wire [`PCR_ADDR_W-1:0]  addr_i,
    input  wire [15:0]             wdata_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output reg  [15:0]             rdata_o,
    input  wire                    ct_done_i,
    input  wire [1:0]              ct_result_i,
    input  wire [CNT_W-1:0]        ct_count_i,
    input  wire                    an_failed_i,
    input  wire [3:0]              led_i,
    output reg                     ct_start_o,
    output reg                     force_link_o,
    output reg                     remote_lb_o,
    output reg  [3:0]              led_o,
    output reg                     tx_disable_o,
    output reg                     an_restart_o,
    output reg                     mdix_auto_o,
    output reg                     mdix_force_o,
    output reg                     an_enable_o,
    output reg                     speed_100_o,
    output reg                     full_duplex_o,
    output reg  [4:0]              adv_o,
    output reg                     irq_o
);

// ****************************************************************
// Storage
// ****************************************************************
    // One copy of each port control bit serves both its addresses
    reg  [15:0]            pctl_ff;
    reg                    ct_en_ff;
    reg                    flnk_ff;
    reg                    rlb_ff;
    reg  [1:0]             ct_res_ff;
    reg  [CNT_W-1:0]       ct_cnt_ff;
    reg  [`PCR_IRQ_W-1:0]  irq_stat_ff;
    reg  [`PCR_IRQ_W-1:0]  irq_mask_ff;
    // Done is sampled so a stale done never ends a fresh start
    reg                    ct_done_ff;

    reg  [15:0]            nxt_pctl;
    reg  [15:0]            ct_word;
    reg  [15:0]            mb_word;
    reg  [15:0]            an_word;
    reg  [15:0]            nxt_rdata;
    reg  [`PCR_IRQ_W-1:0]  irq_set;
    wire                   wr_ct;
    wire                   wr_pc;
    wire                   wr_mb;
    wire                   wr_an;
    wire                   ct_finish;

    assign wr_ct = wr_i && (addr_i == `PCR_OFF_CTEST);
    assign wr_pc = wr_i && (addr_i == `PCR_OFF_PCTL);
    assign wr_mb = wr_i && (addr_i == `PCR_OFF_MBCR);
    assign wr_an = wr_i && (addr_i == `PCR_OFF_ANAR);
    assign ct_finish = ct_en_ff && ct_done_ff;

// ****************************************************************
// Read views of the shared storage
// ****************************************************************
    always @* begin
        ct_word = 16'h0000;
        ct_word[`PCR_CT_RES_HI:`PCR_CT_RES_LO] = ct_res_ff;
        ct_word[`PCR_CT_EN] = ct_en_ff;
        ct_word[`PCR_CT_FLNK] = flnk_ff;
        ct_word[`PCR_CT_RLB] = rlb_ff;
        ct_word[`PCR_CT_CNT_HI:0] = ct_cnt_ff;
        mb_word = 16'h0000;
        mb_word[`PCR_MB_LEDOFF] = pctl_ff[`PCR_PC_LEDOFF];
        mb_word[`PCR_MB_TXDIS] = pctl_ff[`PCR_PC_TXDIS];
        mb_word[`PCR_MB_NOAMDIX] = pctl_ff[`PCR_PC_NOAMDIX];
        mb_word[`PCR_MB_FMDIX] = pctl_ff[`PCR_PC_FMDIX];
        mb_word[`PCR_MB_DPX] = pctl_ff[`PCR_PC_DPX];
        mb_word[`PCR_MB_RSTAN] = pctl_ff[`PCR_PC_RSTAN];
        mb_word[`PCR_MB_ANEN] = pctl_ff[`PCR_PC_ANEN];
        mb_word[`PCR_MB_SPD] = pctl_ff[`PCR_PC_SPD];
        an_word = `PCR_AN_SEL;
        an_word[`PCR_AN_PAUSE] = pctl_ff[`PCR_PC_ADV_HI];
        an_word[`PCR_AN_ADV_HI:`PCR_AN_ADV_LO] =
            pctl_ff[`PCR_PC_ADV_HI-1:0];
    end

// ****************************************************************
// Next port control value from any of its three addresses
// ****************************************************************
    always @* begin
        nxt_pctl = pctl_ff;
        if (wr_pc) begin
            nxt_pctl = wdata_i & `PCR_PC_WMASK;
        end else if (wr_mb) begin
            nxt_pctl[`PCR_PC_LEDOFF] = wdata_i[`PCR_MB_LEDOFF];
            nxt_pctl[`PCR_PC_TXDIS] = wdata_i[`PCR_MB_TXDIS];
            nxt_pctl[`PCR_PC_NOAMDIX] = wdata_i[`PCR_MB_NOAMDIX];
            nxt_pctl[`PCR_PC_FMDIX] = wdata_i[`PCR_MB_FMDIX];
            nxt_pctl[`PCR_PC_DPX] = wdata_i[`PCR_MB_DPX];
            nxt_pctl[`PCR_PC_RSTAN] = wdata_i[`PCR_MB_RSTAN];
            nxt_pctl[`PCR_PC_ANEN] = wdata_i[`PCR_MB_ANEN];
            nxt_pctl[`PCR_PC_SPD] = wdata_i[`PCR_MB_SPD];
        end else if (wr_an) begin
            nxt_pctl[`PCR_PC_ADV_HI] = wdata_i[`PCR_AN_PAUSE];
            nxt_pctl[`PCR_PC_ADV_HI-1:0] =
                wdata_i[`PCR_AN_ADV_HI:`PCR_AN_ADV_LO];
        end
    end

// ****************************************************************
// Read decode and interrupt set sources
// ****************************************************************
    always @* begin
        if (addr_i == `PCR_OFF_CTEST) begin
            nxt_rdata = ct_word;
        end else if (addr_i == `PCR_OFF_PCTL) begin
            nxt_rdata = pctl_ff;
        end else if (addr_i == `PCR_OFF_MBCR) begin
            nxt_rdata = mb_word;
        end else if (addr_i == `PCR_OFF_ANAR) begin
            nxt_rdata = an_word;
        end else if (addr_i == `PCR_OFF_IRQ_STAT) begin
            nxt_rdata = {{(16-`PCR_IRQ_W){1'b0}}, irq_stat_ff};
        end else if (addr_i == `PCR_OFF_IRQ_MASK) begin
            nxt_rdata = {{(16-`PCR_IRQ_W){1'b0}}, irq_mask_ff};
        end else begin
            nxt_rdata = 16'h0000;
        end
        irq_set = {`PCR_IRQ_W{1'b0}};
        irq_set[`PCR_IRQ_CTDONE] = ct_finish;
        irq_set[`PCR_IRQ_ANRST] = wr_pc && wdata_i[`PCR_PC_RSTAN];
    end

// ****************************************************************
// Registers
// ****************************************************************
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            pctl_ff     <= `PCR_PC_RESET;
            ct_en_ff    <= 1'b0;
            flnk_ff     <= 1'b0;
            rlb_ff      <= 1'b0;
            ct_res_ff   <= 2'h0;
            ct_cnt_ff   <= {CNT_W{1'b0}};
            ct_done_ff  <= 1'b0;
            irq_stat_ff <= {`PCR_IRQ_W{1'b0}};
            irq_mask_ff <= {`PCR_IRQ_W{1'b0}};
            rdata_o     <= 16'h0000;
        end else begin
            pctl_ff    <= nxt_pctl;
            ct_done_ff <= ct_done_i && ct_en_ff && !ct_finish;
            // Result and distance are taken beside done, which may be a
            // one-cycle pulse with its data gone by the next cycle
            if (ct_done_i && ct_en_ff && !ct_finish) begin
                ct_res_ff <= ct_result_i;
                ct_cnt_ff <= ct_count_i;
            end
            rdata_o    <= rd_i ? nxt_rdata : 16'h0000;
            // Restart self-clears after one cycle so it acts once
            if (pctl_ff[`PCR_PC_RSTAN] && !wr_pc && !wr_mb) begin
                pctl_ff[`PCR_PC_RSTAN] <= 1'b0;
            end
            if (ct_finish) begin
                ct_en_ff  <= 1'b0;
            end else if (wr_ct && wdata_i[`PCR_CT_EN]) begin
                ct_en_ff  <= 1'b1;
            end
            if (wr_ct) begin
                flnk_ff <= wdata_i[`PCR_CT_FLNK];
                rlb_ff  <= wdata_i[`PCR_CT_RLB];
            end
            if (wr_i && addr_i == `PCR_OFF_IRQ_MASK) begin
                irq_mask_ff <= wdata_i[`PCR_IRQ_W-1:0];
            end
            // Set wins over a write-one clear in the same cycle
            if (wr_i && addr_i == `PCR_OFF_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~wdata_i[`PCR_IRQ_W-1:0])
                               | irq_set;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
        end
    end

// ****************************************************************
// Outputs to the PHY core
// ****************************************************************
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            ct_start_o    <= 1'b0;
            force_link_o  <= 1'b0;
            remote_lb_o   <= 1'b0;
            led_o         <= 4'hf;
            tx_disable_o  <= 1'b0;
            an_restart_o  <= 1'b0;
            mdix_auto_o   <= 1'b1;
            mdix_force_o  <= 1'b0;
            an_enable_o   <= 1'b1;
            speed_100_o   <= 1'b1;
            full_duplex_o <= 1'b1;
            adv_o         <= 5'h1f;
            irq_o         <= 1'b0;
        end else begin
            ct_start_o    <= ct_en_ff;
            force_link_o  <= flnk_ff;
            remote_lb_o   <= rlb_ff;
            // LED pins are active low, so off means driven high
            led_o         <= pctl_ff[`PCR_PC_LEDOFF] ? 4'hf
                                                     : led_i;
            tx_disable_o  <= pctl_ff[`PCR_PC_TXDIS];
            an_restart_o  <= pctl_ff[`PCR_PC_RSTAN];
            mdix_auto_o   <= !pctl_ff[`PCR_PC_NOAMDIX];
            mdix_force_o  <= pctl_ff[`PCR_PC_NOAMDIX] &&
                             pctl_ff[`PCR_PC_FMDIX];
            an_enable_o   <= pctl_ff[`PCR_PC_ANEN];
            speed_100_o   <= pctl_ff[`PCR_PC_SPD];
            full_duplex_o <= pctl_ff[`PCR_PC_DPX];
            adv_o         <= pctl_ff[`PCR_PC_ADV_HI:0];
            irq_o         <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule // pcr_port_regs

/* File: pkg/pcr_regs.vh */
/*
 * Register map, field positions and reset values of the PHY port control
 * and cable test register bank.
 * Assumes a 16-bit register port addressed by byte offset.
 */
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// ****************************************************************
// Offsets
// ****************************************************************
`define PCR_ADDR_W          8
`define PCR_OFF_CTEST       8'hf4
`define PCR_OFF_PCTL        8'hf6
`define PCR_OFF_MBCR        8'he0
`define PCR_OFF_ANAR        8'hec
`define PCR_OFF_IRQ_STAT    8'hfa
`define PCR_OFF_IRQ_MASK    8'hfc

// ****************************************************************
// Cable test register fields
// ****************************************************************
`define PCR_CT_RES_HI       14
`define PCR_CT_RES_LO       13
`define PCR_CT_EN           12
`define PCR_CT_FLNK         11
`define PCR_CT_RLB          9
`define PCR_CT_CNT_HI       8
`define PCR_CT_RES_FAIL     2'h3

// ****************************************************************
// Port control fields
// ****************************************************************
`define PCR_PC_LEDOFF       15
`define PCR_PC_TXDIS        14
`define PCR_PC_RSTAN        13
`define PCR_PC_NOAMDIX      10
`define PCR_PC_FMDIX        9
`define PCR_PC_ANEN         7
`define PCR_PC_SPD          6
`define PCR_PC_DPX          5
`define PCR_PC_ADV_HI       4
`define PCR_PC_RESET        16'h00ff
`define PCR_PC_WMASK        16'he6ff

// ****************************************************************
// Mirror register fields
// ****************************************************************
`define PCR_MB_LEDOFF       0
`define PCR_MB_TXDIS        1
`define PCR_MB_NOAMDIX      3
`define PCR_MB_FMDIX        4
`define PCR_MB_DPX          8
`define PCR_MB_RSTAN        9
`define PCR_MB_ANEN         12
`define PCR_MB_SPD          13
`define PCR_AN_PAUSE        10
`define PCR_AN_ADV_HI       8
`define PCR_AN_ADV_LO       5
`define PCR_AN_SEL          16'h0001

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define PCR_IRQ_W           2
`define PCR_IRQ_CTDONE      0
`define PCR_IRQ_ANRST       1

`endif

/* File: tb/pcr_port_regs_chk.sv */
/* Assertions on the port register bank: control outputs follow writes.
   Sees only the bank's ports; bound to every instance below. */
`timescale 1ns/1ns
module pcr_port_regs_chk (
    input wire        clock_i,
    input wire        resetn_i,
    input wire [7:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        ct_done_i,
    input wire        ct_start_o,
    input wire        force_link_o,
    input wire        remote_lb_o,
    input wire [3:0]  led_o,
    input wire        tx_disable_o,
    input wire        an_restart_o,
    input wire        an_enable_o,
    input wire        speed_100_o,
    input wire        full_duplex_o,
    input wire [4:0]  adv_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    // A finish landing beside a start wins, so demand a quiet engine
    sequence s_ct_go;
        !ct_done_i ##1 wr_i && addr_i == 8'hf4 && wdata_i[12] && !ct_done_i;
    endsequence
    sequence s_an_pulse;
        ##2 an_restart_o ##1 !an_restart_o;
    endsequence
    property p_led;
        wr_i && addr_i == 8'hf6 && wdata_i[15] |-> ##2 led_o == 4'hf;
    endproperty
    a_led: assert property (p_led) else $error("led not off");
    property p_tx;
        wr_i && addr_i == 8'hf6 |-> ##2 tx_disable_o == $past(wdata_i[14], 2);
    endproperty
    a_tx: assert property (p_tx) else $error("tx disable");
    property p_mode;
        wr_i && addr_i == 8'hf6 |-> ##2 {an_enable_o, speed_100_o,
            full_duplex_o} == $past(wdata_i[7:5], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_adv;
        wr_i && addr_i == 8'hf6 |-> ##2 adv_o == $past(wdata_i[4:0], 2);
    endproperty
    a_adv: assert property (p_adv) else $error("advertise");
    property p_an;
        wr_i && addr_i == 8'hf6 && wdata_i[13] |-> s_an_pulse;
    endproperty
    a_an: assert property (p_an) else $error("restart pulse");
    property p_ct_on;
        s_ct_go |-> ##2 ct_start_o;
    endproperty
    a_ct_on: assert property (p_ct_on) else $error("test start");
    property p_ct_off;
        ct_done_i && ct_start_o |-> ##[1:3] !ct_start_o;
    endproperty
    a_ct_off: assert property (p_ct_off) else $error("test end");
    property p_ctl;
        wr_i && addr_i == 8'hf4 |-> ##2 {force_link_o, remote_lb_o} ==
            {$past(wdata_i[11], 2), $past(wdata_i[9], 2)};
    endproperty
    a_ctl: assert property (p_ctl) else $error("link or loop");
endmodule // pcr_port_regs_chk

bind pcr_port_regs pcr_port_regs_chk u_chk (.*);

/* File: tb/tb_top.sv */
/* Self-checking bench for the port register bank: random and corner
   register traffic, cable test runs, interrupts. Checker is bound. */
`timescale 1ns/1ns
module tb_top;
    reg         clock_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    reg         ct_done_i = 1'b0, an_failed_i = 1'b0;
    reg  [7:0]  addr_i = 8'h00;
    reg  [15:0] wdata_i = 16'h0000, lf = 16'h0038, d, w, e;
    reg  [1:0]  ct_result_i = 2'h0;
    reg  [8:0]  ct_count_i = 9'h000;
    reg  [3:0]  led_i = 4'ha;
    wire [15:0] rdata_o;
    wire [3:0]  led_o;
    wire [4:0]  adv_o;
    wire        ct_start_o, force_link_o, remote_lb_o, tx_disable_o;
    wire        an_restart_o, mdix_auto_o, mdix_force_o, an_enable_o;
    wire        speed_100_o, full_duplex_o, irq_o;
    wire [15:0] outs = {1'b0, led_o, tx_disable_o, mdix_auto_o,
        mdix_force_o, an_enable_o, speed_100_o, full_duplex_o, adv_o};
    integer     bad_count = 0, tests_run = 0, i, r;

    pcr_port_regs dut (.*);
    always #5 clock_i = ~clock_i;

    function [15:0] nxt_lfsr(input [15:0] s);
        nxt_lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [15:0] exp_out(input [15:0] p, input [3:0] l);
        exp_out = {1'b0, p[15] ? 4'hf : l, p[14], !p[10], p[10] & p[9],
            p[7:5], p[4:0]};
    endfunction
    task check(input [63:0] nm, input [15:0] ex, input [15:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== ex) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    // One bus cycle; a read compares the word of the following cycle
    task bus(input wr, input [7:0] a, input [15:0] dt, input [63:0] nm);
        begin
            @(posedge clock_i);
            {wr_i, rd_i} <= {wr, !wr};
            addr_i <= a;
            wdata_i <= dt;
            @(posedge clock_i);
            {wr_i, rd_i} <= 2'b00;
            @(negedge clock_i);
            if (!wr) check(nm, dt, rdata_o);
        end
    endtask
    task complete_run;
        begin
            $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        bus(0, 8'hf6, 16'h00ff, "pctl");
        bus(0, 8'he0, 16'h3100, "mbcr");
        bus(0, 8'hec, 16'h05e1, "anar");
        bus(0, 8'h00, 16'h0000, "unmap");
        check("outs", exp_out(16'h00ff, led_i), outs);
        for (i = 0; i < 12; i = i + 1) begin
            lf = nxt_lfsr(lf);
            d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : lf;
            @(posedge clock_i);
            led_i <= lf[15:12];
            an_failed_i <= lf[0];
            bus(1, 8'hf6, d, "");
            bus(0, 8'hf6, d & 16'hc6ff, "pctl");
            check("outs", exp_out(d, led_i), outs);
        end
        bus(1, 8'he0, 16'h0000, "");
        bus(1, 8'hec, 16'h0000, "");
        bus(0, 8'hf6, 16'h0000, "pctl");
        bus(1, 8'he0, 16'hffff, "");
        bus(0, 8'hf6, 16'hc6e0, "pctl");
        // Restart writes left status bit 1 set; mask is still zero
        bus(0, 8'hfa, 16'h0002, "stat");
        check("irq", 16'h0000, {15'h0, irq_o});
        bus(1, 8'hfa, 16'h0002, "");
        bus(1, 8'hfc, 16'h0001, "");
        e = 16'h0000;
        for (r = 0; r < 4; r = r + 1) begin
            w = (r < 2) ? 16'hffff : 16'h1000;
            lf = nxt_lfsr(lf);
            bus(1, 8'hf4, w, "");
            bus(0, 8'hf4, (e & 16'h61ff) | (w & 16'h1a00), "ctest");
            @(posedge clock_i);
            ct_done_i <= 1'b1;
            ct_result_i <= r[1:0];
            ct_count_i <= lf[8:0];
            @(posedge clock_i);
            ct_done_i <= 1'b0;
            ct_result_i <= ~r[1:0];
            ct_count_i <= ~lf[8:0];
            for (i = 0; i < 8 && ct_start_o !== 1'b0; i = i + 1)
                @(negedge clock_i);
            if (ct_start_o !== 1'b0) begin
                bad_count = bad_count + 1;
                complete_run;
            end
            e = {1'b0, r[1:0], 4'h0, lf[8:0]} | (w & 16'h0a00);
            bus(0, 8'hf4, e, "ctest");
            bus(0, 8'hfa, 16'h0001, "stat");
            check("irq", 16'h0001, {15'h0, irq_o});
            bus(1, 8'hfa, 16'h0001, "");
            bus(0, 8'hfa, 16'h0000, "stat");
            check("irq", 16'h0000, {15'h0, irq_o});
        end
        @(posedge clock_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        bus(0, 8'hf6, 16'h00ff, "pctl");
        bus(0, 8'hf4, 16'h0000, "ctest");
        complete_run;
    end
endmodule // tb_top
